// *** dpoc_assertions.sv ***
// Checker for the output pins of the parallel output control block
module dpoc_assertions
  import dpoc_pkg::*;
(
  input wire logic               mclk,
  input wire logic               arst_n,
  input wire logic               pll_lock_raw,
  input wire logic               sleep_n_input,
  input wire logic               output_enable,
  input wire logic               output_edge_select,
  input wire logic               pll_enable,
  input wire logic [GROUP_W-1:0] parallel_out_word_g1,
  input wire logic [GROUP_W-1:0] parallel_out_word_g2,
  input wire logic [GROUP_W-1:0] parallel_out_word_g3,
  input wire logic               data_oe,
  input wire logic               out_clk,
  input wire logic               out_clk_oe,
  input wire logic               lock_flag,
  input wire logic               lock_flag_oe
);
  // ****************
  // Pin relations
  // ****************
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [WORD_W-1:0] w;
  // Whole word, so a change in any group counts as a launch
  assign w = {parallel_out_word_g3, parallel_out_word_g2, parallel_out_word_g1};
  property p_drive; (output_enable && pll_lock_raw && sleep_n_input)[*6] |-> data_oe && out_clk_oe; endproperty
  a_drive: assert property (p_drive) else $error("outputs not driven");
  property p_float; (!output_enable && pll_lock_raw && sleep_n_input)[*6] |-> !data_oe && !out_clk_oe && lock_flag; endproperty
  a_float: assert property (p_float) else $error("float with lock kept failed");
  property p_lock; (pll_lock_raw && sleep_n_input)[*5] |-> lock_flag; endproperty
  a_lock: assert property (p_lock) else $error("lock flag low while locked");
  property p_unlock; !pll_lock_raw[*5] |-> !lock_flag && !data_oe && !out_clk_oe; endproperty
  a_unlock: assert property (p_unlock) else $error("unlocked but outputs on");
  property p_awake; sleep_n_input[*5] |-> pll_enable && lock_flag_oe; endproperty
  a_awake: assert property (p_awake) else $error("receiver not running");
  property p_sleep; !sleep_n_input[*5] |-> !pll_enable && !lock_flag_oe && !data_oe && !out_clk_oe; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not float");
  property p_rise; (output_edge_select[*5] ##0 $changed(w)) |-> $rose(out_clk); endproperty
  a_rise: assert property (p_rise) else $error("word not on rising edge");
  property p_fall; (!output_edge_select[*5] ##0 $changed(w)) |-> $fell(out_clk); endproperty
  a_fall: assert property (p_fall) else $error("word not on falling edge");
endmodule : dpoc_assertions

bind dpoc_top dpoc_assertions i_chk (.*);

// *** dpoc_pkg.sv ***
// Constants and types for the parallel output control block
package dpoc_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
  localparam logic [7:0] LAST_WORD_OFS = 8'h10;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_OUT_GATE_BIT = 0;
  localparam logic [0:0] CTRL_RESET = 1'h1;
  localparam int EV_LOCK_GAIN = 0;
  localparam int EV_LOCK_LOSS = 1;
  localparam int EV_OVERRUN   = 2;
  localparam int EV_RESV_HIGH = 3;
  localparam int EV_W = 4;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  localparam int ST_LOCK_BIT  = 0;
  localparam int ST_AWAKE_BIT = 1;
  localparam int ST_OE_BIT    = 2;
  localparam int ST_EDGE_BIT  = 3;
  localparam int ST_RESV_BIT  = 4;
  localparam int ST_PEND_BIT  = 5;

  // ****************************************************************
  // Widths and timing
  // ****************************************************************
  localparam int WORD_W  = 24;
  localparam int GROUP_W = 8;
  localparam int NPINS   = 5;
  localparam int MCLK_HZ = 10_000_000;
  localparam int OCLK_HZ = 2_500_000;
  // Half period of the output clock in mclk cycles, at least one
  localparam int OCLK_HALF_CNT = (MCLK_HZ / OCLK_HZ / 2 < 1) ? 1 : MCLK_HZ / OCLK_HZ / 2;
  localparam int CNT_W = 4;

  // Synchronised pin vector positions
  localparam int PIN_LOCK  = 0;
  localparam int PIN_SLEEP = 1;
  localparam int PIN_OE    = 2;
  localparam int PIN_EDGE  = 3;
  localparam int PIN_RESV  = 4;

  typedef enum logic [1:0] {
    DPOC_OCK_OFF  = 2'b00,
    DPOC_OCK_LOW  = 2'b01,
    DPOC_OCK_HIGH = 2'b10
  } dpoc_ock_t;

endpackage : dpoc_pkg

// *** dpoc_sink.sv ***
// Downstream capture model for the parallel output word
module dpoc_sink
  import dpoc_pkg::*;
(
  input  wire logic               out_clk,
  input  wire logic               data_oe,
  input  wire logic               edge_sel,
  input  wire logic [GROUP_W-1:0] g1,
  input  wire logic [GROUP_W-1:0] g2,
  input  wire logic [GROUP_W-1:0] g3,
  output logic      [WORD_W-1:0]  word
);
  // ****************
  // Capture
  // ****************
  // Samples on the edge opposite the launch, mid-period, where the word is settled
  always @(out_clk) begin
    if (data_oe === 1'h1 && out_clk !== edge_sel) word <= {g3, g2, g1};
  end
endmodule : dpoc_sink

// *** dpoc_top.sv ***
// Parallel output control: output word groups, output clock, lock flag, APB
//
// Overview of operation
// - Output enable high drives data and clock while the CTRL out gate bit is set
// - Output enable low floats data and clock, lock flag and PLL kept
// - Lock flag high while PLL locked
// - Unlocked: flag low, data and clock floated
// - Sleep input high: receiver fully running
// - Sleep low: float all, PLL shut down
// - Edge select high: launch on rising edge
// - Edge select low: launch on falling edge
// - Word presented as three byte groups
module dpoc_top
  import dpoc_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                arst_n,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  output logic                     irq,
  // Pins from outside the mclk domain
  input  wire logic                pll_lock_raw,
  input  wire logic                sleep_n_input,
  input  wire logic                output_enable,
  input  wire logic                output_edge_select,
  input  wire logic                reserved_tie_low_input,
  // Recovered words from clock-data recovery (mclk domain)
  input  wire logic [WORD_W-1:0]   rx_word,
  input  wire logic                rx_word_valid,
  // PLL power control
  output logic                     pll_enable,
  // Parallel output side, three byte groups
  output logic [GROUP_W-1:0]       parallel_out_word_g1,
  output logic [GROUP_W-1:0]       parallel_out_word_g2,
  output logic [GROUP_W-1:0]       parallel_out_word_g3,
  output logic                     data_oe,
  output logic                     out_clk,
  output logic                     out_clk_oe,
  output logic                     lock_flag,
  output logic                     lock_flag_oe
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [NPINS-1:0] pin_meta;
  logic [NPINS-1:0] pin_sync;
  logic [NPINS-1:0] pins_raw;

  assign pins_raw = {reserved_tie_low_input, output_edge_select, output_enable,
                     sleep_n_input, pll_lock_raw};

  // Two flops; only the second stage feeds logic
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pins_raw;
      pin_sync <= pin_meta;
    end
  end

  logic awake;
  logic locked;
  logic oe_pin;
  logic edge_rise;
  logic resv_high;

  assign awake     = pin_sync[PIN_SLEEP];
  assign locked    = pin_sync[PIN_LOCK] & awake;
  assign oe_pin    = pin_sync[PIN_OE];
  assign edge_rise = pin_sync[PIN_EDGE];
  assign resv_high = pin_sync[PIN_RESV];

  // ****************************************************************
  // Output clock, word launch and output enables
  // ****************************************************************
  dpoc_ock_t        ock_state;
  dpoc_ock_t        next_ock_state;
  logic [CNT_W-1:0] ock_cnt;
  logic [CNT_W-1:0] next_ock_cnt;
  logic [WORD_W-1:0] hold_word;
  logic [WORD_W-1:0] next_hold_word;
  logic             hold_full;
  logic             next_hold_full;
  logic [WORD_W-1:0] out_word;
  logic [WORD_W-1:0] next_out_word;
  logic             next_out_clk;
  logic             next_data_oe;
  logic             next_out_clk_oe;
  logic             next_lock_flag;
  logic             next_lock_flag_oe;
  logic             next_pll_enable;
  logic             out_gate;
  logic             launch;
  logic             overrun_ev;

  // Clock toggles every half period while locked; stops when not
  always_comb begin
    next_ock_state = ock_state;
    next_ock_cnt   = ock_cnt;
    launch         = 1'b0;
    unique case (ock_state)
      DPOC_OCK_OFF: begin
        next_ock_cnt = '0;
        if (locked) begin
          next_ock_state = DPOC_OCK_LOW;
        end
      end
      DPOC_OCK_LOW: begin
        if (!locked) begin
          next_ock_state = DPOC_OCK_OFF;
        end else if (ock_cnt == CNT_W'(OCLK_HALF_CNT - 1)) begin
          next_ock_cnt   = '0;
          next_ock_state = DPOC_OCK_HIGH;
          launch         = edge_rise;
        end else begin
          next_ock_cnt = ock_cnt + CNT_W'(1);
        end
      end
      DPOC_OCK_HIGH: begin
        if (!locked) begin
          next_ock_state = DPOC_OCK_OFF;
        end else if (ock_cnt == CNT_W'(OCLK_HALF_CNT - 1)) begin
          next_ock_cnt   = '0;
          next_ock_state = DPOC_OCK_LOW;
          launch         = !edge_rise;
        end else begin
          next_ock_cnt = ock_cnt + CNT_W'(1);
        end
      end
      default: begin
        next_ock_state = DPOC_OCK_OFF;
        next_ock_cnt   = '0;
      end
    endcase
  end

  // One held word is launched per clock period; a second word before launch overwrites it
  always_comb begin
    next_hold_word = hold_word;
    next_hold_full = hold_full;
    next_out_word  = out_word;
    overrun_ev     = 1'b0;
    if (launch && hold_full) begin
      next_out_word  = hold_word;
      next_hold_full = 1'b0;
    end
    if (rx_word_valid && locked) begin
      next_hold_word = rx_word;
      next_hold_full = 1'b1;
      overrun_ev     = hold_full && !(launch && hold_full);
    end
    if (!locked) begin
      next_hold_full = 1'b0;
    end
  end

  // Pin drivers: data and clock need enable, lock and awake
  always_comb begin
    next_out_clk      = (next_ock_state == DPOC_OCK_HIGH);
    next_data_oe      = oe_pin && locked && out_gate;
    next_out_clk_oe   = oe_pin && locked && out_gate;
    next_lock_flag    = locked;
    next_lock_flag_oe = awake;
    next_pll_enable   = awake;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ock_state    <= DPOC_OCK_OFF;
      ock_cnt      <= '0;
      hold_word    <= '0;
      hold_full    <= 1'b0;
      out_word     <= '0;
      out_clk      <= 1'b0;
      data_oe      <= 1'b0;
      out_clk_oe   <= 1'b0;
      lock_flag    <= 1'b0;
      lock_flag_oe <= 1'b0;
      pll_enable   <= 1'b0;
    end else begin
      ock_state    <= next_ock_state;
      ock_cnt      <= next_ock_cnt;
      hold_word    <= next_hold_word;
      hold_full    <= next_hold_full;
      out_word     <= next_out_word;
      out_clk      <= next_out_clk;
      data_oe      <= next_data_oe;
      out_clk_oe   <= next_out_clk_oe;
      lock_flag    <= next_lock_flag;
      lock_flag_oe <= next_lock_flag_oe;
      pll_enable   <= next_pll_enable;
    end
  end

  // Byte groups straight from the launched word register
  assign parallel_out_word_g1 = out_word[7:0];
  assign parallel_out_word_g2 = out_word[15:8];
  assign parallel_out_word_g3 = out_word[23:16];

  // ****************************************************************
  // APB registers and interrupt
  // ****************************************************************
  logic            ctrl;
  logic            next_ctrl;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] next_irq_stat;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] next_irq_mask;
  logic            locked_d;
  logic            resv_d;
  logic [EV_W-1:0] events;
  logic            acc_done;
  logic            next_pready;
  logic [31:0]     next_prdata;
  logic            next_pslverr;
  logic            next_irq;
  logic [31:0]     status_word;

  assign out_gate = ctrl;
  assign acc_done = psel && penable && pready;

  assign status_word = {26'h000_0000, hold_full, resv_high, edge_rise, oe_pin, awake, locked};

  always_comb begin
    events = '0;
    events[EV_LOCK_GAIN] = locked && !locked_d;
    events[EV_LOCK_LOSS] = !locked && locked_d;
    events[EV_OVERRUN]   = overrun_ev;
    events[EV_RESV_HIGH] = resv_high && !resv_d;
  end

  // One wait state: pready rises in the second access cycle, read data with it; write lands on the edge that ends it
  always_comb begin
    next_ctrl     = ctrl;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_pready   = psel && penable && !pready;
    next_prdata   = prdata;
    next_pslverr  = 1'b0;
    if (psel && penable && !pready) begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        CTRL_OFS:      next_prdata = {31'h0000_0000, ctrl};
        STATUS_OFS:    next_prdata = status_word;
        IRQ_STAT_OFS:  next_prdata = {28'h000_0000, irq_stat};
        IRQ_MASK_OFS:  next_prdata = {28'h000_0000, irq_mask};
        LAST_WORD_OFS: next_prdata = {8'h00, out_word};
        default:       next_pslverr = 1'b1;
      endcase
    end
    if (acc_done && pwrite) begin
      unique case (paddr)
        CTRL_OFS:     next_ctrl = pwdata[CTRL_OUT_GATE_BIT];
        IRQ_MASK_OFS: next_irq_mask = pwdata[EV_W-1:0];
        IRQ_STAT_OFS: next_irq_stat = irq_stat & ~pwdata[EV_W-1:0];
        default:      next_ctrl = ctrl;
      endcase
    end
    // Set after clear so a same-cycle event is never lost
    next_irq_stat = next_irq_stat | events;
    next_irq      = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl     <= CTRL_RESET[0];
      irq_mask <= IRQ_MASK_RESET;
      irq_stat <= '0;
      locked_d <= 1'b0;
      resv_d   <= 1'b0;
      pready   <= 1'b0;
      prdata   <= '0;
      pslverr  <= 1'b0;
      irq      <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      locked_d <= locked;
      resv_d   <= resv_high;
      pready   <= next_pready;
      prdata   <= next_prdata;
      pslverr  <= next_pslverr;
      irq      <= next_irq;
    end
  end

endmodule : dpoc_top

// *** tb_top.sv ***
// Testbench for the parallel output control block
module tb_top
  import dpoc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr, irq, er;
  logic        lk, slp, oe, es, rsv, vld, pll_en, d_oe, ock, ock_oe, lf, lf_oe;
  logic [7:0]  paddr, g1, g2, g3;
  logic [31:0] pwdata, prdata, q;
  logic [23:0] rxw, got;
  int          miscompares, comparisons;
  always #50 mclk = ~mclk;
  dpoc_top i_dut (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .pll_lock_raw(lk), .sleep_n_input(slp), .output_enable(oe), .output_edge_select(es),
    .reserved_tie_low_input(rsv), .rx_word(rxw), .rx_word_valid(vld), .pll_enable(pll_en),
    .parallel_out_word_g1(g1), .parallel_out_word_g2(g2), .parallel_out_word_g3(g3),
    .data_oe(d_oe), .out_clk(ock), .out_clk_oe(ock_oe), .lock_flag(lf), .lock_flag_oe(lf_oe));
  dpoc_sink i_sink (.out_clk(ock), .data_oe(d_oe), .edge_sel(es), .g1(g1), .g2(g2), .g3(g3), .word(got));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic close_out;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // Holds the request until pready is seen at an edge; bounded wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    miscompares += (n >= 20);
    if (n >= 20) close_out();
    q = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0000_0000);
    chk(q, e);
  endtask : rd
  // One word in, then wait for the sink to capture it
  task automatic send(input logic [23:0] w);
    int n;
    rxw <= w;
    vld <= 1'h1;
    @(posedge mclk);
    vld <= 1'h0;
    n = 0;
    // First sample after launch: the clock still sits at the launch level
    while ({g3, g2, g1} !== w && n < 40) begin
      @(posedge mclk);
      n++;
    end
    miscompares += (n >= 40);
    if (n >= 40) close_out();
    chk(ock, es);
    // Sink takes the word on the opposite edge, half a period later
    repeat (3) @(posedge mclk);
    chk(got, w);
    chk({g3, g2, g1}, w);
  endtask : send
  // ****************
  // Sequence
  // ****************
  initial begin
    {mclk, arst_n, psel, penable, pwrite, lk, vld} = 7'h00;
    {slp, oe, es} = 3'h7;
    rsv = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rxw = 24'h00_0000;
    repeat (8) @(posedge mclk);
    arst_n <= 1'h1;
    rd(CTRL_OFS, 32'h0000_0001);
    rd(IRQ_MASK_OFS, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    chk(er, 1'h1);
    lk <= 1'h1;
    repeat (8) @(posedge mclk);
    chk({lf, lf_oe, d_oe, ock_oe, pll_en}, 5'h1f);
    rd(STATUS_OFS, 32'h0000_000f);
    rd(IRQ_STAT_OFS, 32'h0000_0001);
    apb(1'h1, IRQ_MASK_OFS, 32'h0000_000f);
    @(posedge mclk);
    chk(irq, 1'h1);
    apb(1'h1, IRQ_STAT_OFS, 32'h0000_000f);
    @(posedge mclk);
    chk(irq, 1'h0);
    for (int i = 1; i >= 0; i--) begin
      es <= i[0];
      repeat (6) @(posedge mclk);
      send(24'ha5_5a3c ^ 24'(i));
      send(24'h3c_c3f0 ^ 24'(i));
    end
    // Three back-to-back words force at least one overwrite
    rxw <= 24'h01_0203;
    vld <= 1'h1;
    @(posedge mclk);
    rxw <= 24'h04_0506;
    @(posedge mclk);
    send(24'h07_0809);
    rd(IRQ_STAT_OFS, 32'h0000_0004);
    apb(1'h1, IRQ_STAT_OFS, 32'h0000_000f);
    oe <= 1'h0;
    repeat (6) @(posedge mclk);
    chk({d_oe, ock_oe, lf, pll_en}, 4'h3);
    oe <= 1'h1;
    lk <= 1'h0;
    repeat (6) @(posedge mclk);
    chk({lf, d_oe, ock_oe}, 3'h0);
    rd(IRQ_STAT_OFS, 32'h0000_0002);
    apb(1'h1, IRQ_STAT_OFS, 32'h0000_000f);
    lk <= 1'h1;
    repeat (6) @(posedge mclk);
    slp <= 1'h0;
    repeat (6) @(posedge mclk);
    chk({pll_en, lf_oe, d_oe, ock_oe}, 4'h0);
    rsv <= 1'h1;
    repeat (6) @(posedge mclk);
    rd(IRQ_STAT_OFS, 32'h0000_000b);
    rd(STATUS_OFS, 32'h0000_0014);
    close_out();
  end
endmodule : tb_top
